// ### logic/dlsc_core.sv
// dual lane compute core: two processing elements, staging for the data
// and program memory buses, and a selective instruction cache
// assumes memories answer exactly one cycle after a request shows on a bus
//
// Notes on behaviour
// - primary element always runs; secondary only while dual_lane_enable is set
// - in dual-lane mode both elements run each command on their own data
// - dual-lane mode doubles the words moved between memory and elements
// - each dual-lane bus access moves two values, one per element
// - alu, multiplier and shifter each complete every operation in one cycle
// - the three units inside an element work side by side concurrently
// - one command may run an alu and a multiplier operation together
// - units handle single float, extended 40-bit float and fixed point
// - each element holds 32 registers, 16 primary and 16 alternate
// - primary_lane_regs and secondary_lane_regs are separate sets indexed 0 to 15
// - data_memory_bus carries data only; program_memory_bus carries both
// - one cycle may take two operands per bus plus one instruction
// - the cache keeps only instructions whose fetch met a program bus data access
`timescale 1ns/1ps
module dlsc_core #(
	parameter int IC_DEPTH = dlsc_pkg::IC_DEPTH
) (
	input  wire logic                          clock_i,
	input  wire logic                          arst_n_i,
	input  wire logic                          mode_we_i,
	input  wire logic [dlsc_pkg::MODE_W-1:0]   mode_wdata_i,
	input  wire dlsc_pkg::dlsc_cmd_t           cmd_i,
	input  wire logic                          fetch_req_i,
	input  wire logic [dlsc_pkg::ADDR_W-1:0]   fetch_addr_i,
	input  wire logic [2*dlsc_pkg::DATA_W-1:0] dm_rdata_i,
	input  wire logic [2*dlsc_pkg::DATA_W-1:0] pm_rdata_i,
	output logic [dlsc_pkg::MODE_W-1:0]        mode_o,
	output logic                               fetch_ready_o,
	output logic                               instr_valid_o,
	output logic [dlsc_pkg::INSTR_W-1:0]       instr_o,
	output dlsc_pkg::dlsc_mreq_t               dm_req_o,
	output dlsc_pkg::dlsc_mreq_t               pm_req_o,
	output dlsc_pkg::dlsc_flags_t              pri_flags_o,
	output dlsc_pkg::dlsc_flags_t              sec_flags_o
);
	localparam int DW = dlsc_pkg::DATA_W;
	localparam int AW = dlsc_pkg::ADDR_W;
	localparam int IW = dlsc_pkg::INSTR_W;
	localparam int XW = dlsc_pkg::IDX_W;
	localparam int IXW = $clog2(IC_DEPTH);

	logic [dlsc_pkg::MODE_W-1:0] mode_q;
	logic [dlsc_pkg::MODE_W-1:0] mode_d;
	logic                        dual;
	logic [1:0]                  lane_act;
	dlsc_pkg::dlsc_flags_t       lane_flags [2];
	logic [1:0][DW-1:0]          st_data [2];
	logic [1:0][DW-1:0]          ld_data [2];
	logic [1:0]                  ld_en [2];
	logic [1:0][XW-1:0]          ld_idx;
	logic [1:0][XW-1:0]          st_idx;
	logic [2*DW-1:0]             rdat [2];
	dlsc_pkg::dlsc_xfer_t        xf [2];
	dlsc_pkg::dlsc_mreq_t        req_d [2];
	dlsc_pkg::dlsc_mreq_t        req_q [2];
	dlsc_pkg::dlsc_ldtag_t       tag1_d [2];
	dlsc_pkg::dlsc_ldtag_t       tag1_q [2];
	dlsc_pkg::dlsc_ldtag_t       tag2_q [2];

	dlsc_pkg::dlsc_fstate_t      fst_q;
	dlsc_pkg::dlsc_fstate_t      fst_d;
	logic [AW-1:0]               faddr_q;
	logic [AW-1:0]               faddr_d;
	logic                        fill_q;
	logic                        fill_d;
	logic                        ready_q;
	logic                        ready_d;
	logic                        ivalid_q;
	logic                        ivalid_d;
	logic [IW-1:0]               instr_q;
	logic [IW-1:0]               instr_d;
	logic                        conflict;
	logic                        hit;
	logic                        issue;
	logic [IXW-1:0]              look_ix;
	logic                        ic_val_q [IC_DEPTH];
	logic                        ic_val_d [IC_DEPTH];
	logic [AW-1:0]               ic_addr_q [IC_DEPTH];
	logic [AW-1:0]               ic_addr_d [IC_DEPTH];
	logic [IW-1:0]               ic_data_q [IC_DEPTH];
	logic [IW-1:0]               ic_data_d [IC_DEPTH];

	// mode control: lane enable, alternate bank and precision select
	always_comb
	begin
		mode_d = mode_q;
		if (mode_we_i)
			mode_d = mode_wdata_i;
		dual = mode_q[dlsc_pkg::MODE_DUAL_BIT];
		lane_act = {dual, 1'b1};
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			mode_q <= dlsc_pkg::MODE_RST;
		else
			mode_q <= mode_d;
	end

	// lane 0 owns primary_lane_regs, lane 1 owns secondary_lane_regs
	assign rdat[0] = dm_rdata_i;
	assign rdat[1] = pm_rdata_i;

	for (genvar g = 0; g < 2; g++)
	begin : g_lane
		always_comb
		begin
			for (int p = 0; p < 2; p++)
			begin
				ld_en[g][p] = tag2_q[p].en && (g == 0 || tag2_q[p].pair);
				ld_data[g][p] = rdat[p][g*DW +: DW];
			end
		end

		// both lanes see the very same command word
		dlsc_pe u_pe (
			.clock_i    (clock_i),
			.arst_n_i   (arst_n_i),
			.active_i   (lane_act[g]),
			.alt_bank_i (mode_q[dlsc_pkg::MODE_ALT_BIT]),
			.ext_prec_i (mode_q[dlsc_pkg::MODE_EXT_BIT]),
			.cmd_i      (cmd_i),
			.ld_en_i    (ld_en[g]),
			.ld_idx_i   (ld_idx),
			.ld_data_i  (ld_data[g]),
			.st_idx_i   (st_idx),
			.st_data_o  (st_data[g]),
			.flags_o    (lane_flags[g])
		);
	end

	// bus staging: entry 0 is the data bus, entry 1 the program bus
	always_comb
	begin
		xf[0] = cmd_i.dm;
		xf[1] = cmd_i.pm;
		for (int p = 0; p < 2; p++)
		begin
			st_idx[p] = xf[p].idx;
			ld_idx[p] = tag2_q[p].idx;
			// both buses may move operands in the same cycle
			req_d[p].req = cmd_i.valid && xf[p].en;
			req_d[p].we = !xf[p].load;
			req_d[p].pair = dual;
			req_d[p].ifetch = 1'b0;
			req_d[p].addr = xf[p].addr;
			if (dual)
				req_d[p].wdata = {st_data[1][p], st_data[0][p]};
			else
				req_d[p].wdata = {{DW{1'b0}}, st_data[0][p]};
			tag1_d[p].en = req_d[p].req && xf[p].load;
			tag1_d[p].pair = dual;
			tag1_d[p].idx = xf[p].idx;
		end
		// an instruction read takes the program bus only when data leaves it free
		if (issue)
		begin
			req_d[1].req = 1'b1;
			req_d[1].we = 1'b0;
			req_d[1].pair = 1'b0;
			req_d[1].ifetch = 1'b1;
			req_d[1].addr = faddr_d;
		end
	end

	// fetch path with a direct mapped cache filled only on bus conflicts
	always_comb
	begin
		conflict = cmd_i.valid && cmd_i.pm.en;
		look_ix = fetch_addr_i[IXW-1:0];
		hit = ic_val_q[look_ix] && ic_addr_q[look_ix] == fetch_addr_i;
		fst_d = fst_q;
		faddr_d = faddr_q;
		fill_d = fill_q;
		instr_d = instr_q;
		ivalid_d = 1'b0;
		issue = 1'b0;
		ic_val_d = ic_val_q;
		ic_addr_d = ic_addr_q;
		ic_data_d = ic_data_q;
		case (fst_q)
			dlsc_pkg::F_IDLE:
			begin
				if (fetch_req_i)
				begin
					faddr_d = fetch_addr_i;
					if (!conflict)
					begin
						issue = 1'b1;
						fill_d = 1'b0;
						fst_d = dlsc_pkg::F_WAIT;
					end
					else if (hit)
					begin
						instr_d = ic_data_q[look_ix];
						ivalid_d = 1'b1;
					end
					else
					begin
						fill_d = 1'b1;
						fst_d = dlsc_pkg::F_MISS;
					end
				end
			end
			dlsc_pkg::F_MISS:
			begin
				if (!conflict)
				begin
					issue = 1'b1;
					fst_d = dlsc_pkg::F_WAIT;
				end
			end
			dlsc_pkg::F_WAIT: fst_d = dlsc_pkg::F_CATCH;
			dlsc_pkg::F_CATCH:
			begin
				instr_d = pm_rdata_i[IW-1:0];
				ivalid_d = 1'b1;
				fst_d = dlsc_pkg::F_IDLE;
				// instructions fetched without a conflict never enter the cache
				if (fill_q)
				begin
					ic_val_d[faddr_q[IXW-1:0]] = 1'b1;
					ic_addr_d[faddr_q[IXW-1:0]] = faddr_q;
					ic_data_d[faddr_q[IXW-1:0]] = pm_rdata_i[IW-1:0];
				end
			end
			default: fst_d = dlsc_pkg::F_IDLE;
		endcase
		ready_d = fst_d == dlsc_pkg::F_IDLE;
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			fst_q <= dlsc_pkg::F_IDLE;
			faddr_q <= '0;
			fill_q <= 1'b0;
			ready_q <= 1'b1;
			ivalid_q <= 1'b0;
			instr_q <= '0;
			for (int i = 0; i < IC_DEPTH; i++)
			begin
				ic_val_q[i] <= 1'b0;
				ic_addr_q[i] <= '0;
				ic_data_q[i] <= '0;
			end
		end
		else
		begin
			fst_q <= fst_d;
			faddr_q <= faddr_d;
			fill_q <= fill_d;
			ready_q <= ready_d;
			ivalid_q <= ivalid_d;
			instr_q <= instr_d;
			ic_val_q <= ic_val_d;
			ic_addr_q <= ic_addr_d;
			ic_data_q <= ic_data_d;
		end
	end

	// load tags ride two stages so back to back loads cannot overwrite each other
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			for (int p = 0; p < 2; p++)
			begin
				req_q[p] <= dlsc_pkg::MREQ_RST;
				tag1_q[p] <= dlsc_pkg::TAG_RST;
				tag2_q[p] <= dlsc_pkg::TAG_RST;
			end
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				req_q[p] <= req_d[p];
				tag1_q[p] <= tag1_d[p];
				tag2_q[p] <= tag1_q[p];
			end
		end
	end

	assign mode_o = mode_q;
	assign fetch_ready_o = ready_q;
	assign instr_valid_o = ivalid_q;
	assign instr_o = instr_q;
	assign dm_req_o = req_q[0];
	assign pm_req_o = req_q[1];
	assign pri_flags_o = lane_flags[0];
	assign sec_flags_o = lane_flags[1];
endmodule

// ### logic/dlsc_pe.sv
// one processing element: alu, multiplier and shifter beside a register
// file of two banks of sixteen; every result lands at the next clock edge
// assumes the top gates it with active_i and aligns load data to its tags
`timescale 1ns/1ps
module dlsc_pe (
	input  wire logic                             clock_i,
	input  wire logic                             arst_n_i,
	input  wire logic                             active_i,
	input  wire logic                             alt_bank_i,
	input  wire logic                             ext_prec_i,
	input  wire dlsc_pkg::dlsc_cmd_t              cmd_i,
	input  wire logic [1:0]                       ld_en_i,
	input  wire logic [1:0][dlsc_pkg::IDX_W-1:0]  ld_idx_i,
	input  wire logic [1:0][dlsc_pkg::DATA_W-1:0] ld_data_i,
	input  wire logic [1:0][dlsc_pkg::IDX_W-1:0]  st_idx_i,
	output logic      [1:0][dlsc_pkg::DATA_W-1:0] st_data_o,
	output dlsc_pkg::dlsc_flags_t                 flags_o
);
	localparam int W = dlsc_pkg::REG_W;
	localparam int L = dlsc_pkg::FIX_LSB;
	localparam int N = 2 * dlsc_pkg::NREG;

	dlsc_pkg::dlsc_word_t  rf_q [N];
	dlsc_pkg::dlsc_word_t  rf_d [N];
	dlsc_pkg::dlsc_flags_t flags_q;
	dlsc_pkg::dlsc_flags_t flags_d;
	dlsc_pkg::dlsc_word_t  ax;
	dlsc_pkg::dlsc_word_t  ay;
	dlsc_pkg::dlsc_word_t  mx;
	dlsc_pkg::dlsc_word_t  my;
	dlsc_pkg::dlsc_word_t  sx;
	dlsc_pkg::dlsc_word_t  alu_r;
	dlsc_pkg::dlsc_word_t  mul_r;
	dlsc_pkg::dlsc_word_t  shf_r;
	logic                  alu_v;
	logic [W-L-1:0]        fs;
	logic [W-L-1:0]        fd;
	logic [W-L-1:0]        sv;
	logic [2*(W-L)-1:0]    fp;
	logic [7:0]            namt;

	// zero, underflow and overflow folding; no denormals, truncating
	function automatic dlsc_pkg::dlsc_word_t f_pack(input logic s, input logic [9:0] e,
		input logic [30:0] m, input logic z);
		if (z || e[9] || e == 10'h000)
			f_pack = '0;
		else if (e >= dlsc_pkg::FP_EMAX)
			f_pack = {s, 8'hff, 31'h0000_0000};
		else
			f_pack = {s, e[7:0], m};
	endfunction

	function automatic dlsc_pkg::dlsc_word_t f_mul(input dlsc_pkg::dlsc_word_t a, b);
		logic [63:0] p;
		logic [9:0]  e;
		p = {1'b1, a[30:0]} * {1'b1, b[30:0]};
		e = {2'h0, a[38:31]} + {2'h0, b[38:31]} - dlsc_pkg::FP_BIAS + {9'h000, p[63]};
		f_mul = f_pack(a[39] ^ b[39], e, p[63] ? p[62:32] : p[61:31],
			a[38:31] == 8'h00 || b[38:31] == 8'h00);
	endfunction

	function automatic dlsc_pkg::dlsc_word_t f_add(input dlsc_pkg::dlsc_word_t a, b,
		input logic sub);
		dlsc_pkg::dlsc_word_t hi;
		dlsc_pkg::dlsc_word_t lo;
		logic [32:0]          r;
		logic [9:0]           e;
		hi = a;
		lo = {b[39] ^ sub, b[38:0]};
		if (lo[38:0] > hi[38:0])
		begin
			hi = lo;
			lo = a;
		end
		r = {1'b0, hi[38:31] != 8'h00, hi[30:0]};
		if (hi[39] == lo[39])
			r = r + ({1'b0, lo[38:31] != 8'h00, lo[30:0]} >> (hi[38:31] - lo[38:31]));
		else
			r = r - ({1'b0, lo[38:31] != 8'h00, lo[30:0]} >> (hi[38:31] - lo[38:31]));
		e = {2'h0, hi[38:31]};
		if (r[32])
		begin
			r = r >> 1;
			e = e + 10'h001;
		end
		for (int i = 0; i < 32; i++)
			if (!r[31] && r != 33'h0)
			begin
				r = r << 1;
				e = e - 10'h001;
			end
		f_add = f_pack(hi[39], e, r[30:0], r == 33'h0);
	endfunction

	always_comb
	begin
		ax = rf_q[{alt_bank_i, cmd_i.alu_x}];
		ay = rf_q[{alt_bank_i, cmd_i.alu_y}];
		mx = rf_q[{alt_bank_i, cmd_i.mul_x}];
		my = rf_q[{alt_bank_i, cmd_i.mul_y}];
		sx = rf_q[{alt_bank_i, cmd_i.shf_x}];
		fs = ax[W-1:L] + ay[W-1:L];
		fd = ax[W-1:L] - ay[W-1:L];
		alu_v = 1'b0;
		// three units evaluate side by side from their own read ports
		case (cmd_i.alu_op)
			dlsc_pkg::ALU_ADD:
			begin
				alu_r = {fs, {L{1'b0}}};
				alu_v = ax[W-1] == ay[W-1] && fs[W-L-1] != ax[W-1];
			end
			dlsc_pkg::ALU_SUB:
			begin
				alu_r = {fd, {L{1'b0}}};
				alu_v = ax[W-1] != ay[W-1] && fd[W-L-1] != ax[W-1];
			end
			dlsc_pkg::ALU_AND: alu_r = {ax[W-1:L] & ay[W-1:L], {L{1'b0}}};
			dlsc_pkg::ALU_OR:  alu_r = {ax[W-1:L] | ay[W-1:L], {L{1'b0}}};
			dlsc_pkg::ALU_XOR: alu_r = {ax[W-1:L] ^ ay[W-1:L], {L{1'b0}}};
			dlsc_pkg::ALU_FADD:
			begin
				alu_r = f_add(ax, ay, 1'b0);
				alu_v = alu_r[38:31] == 8'hff;
			end
			dlsc_pkg::ALU_FSUB:
			begin
				alu_r = f_add(ax, ay, 1'b1);
				alu_v = alu_r[38:31] == 8'hff;
			end
			default: alu_r = ax;
		endcase
		fp = $signed(mx[W-1:L]) * $signed(my[W-1:L]);
		if (cmd_i.mul_op == dlsc_pkg::MUL_FLT)
			mul_r = f_mul(mx, my);
		else
			mul_r = {fp[W-L-1:0], {L{1'b0}}};
		namt = -cmd_i.shf_amt;
		if (!cmd_i.shf_amt[7])
			sv = sx[W-1:L] << cmd_i.shf_amt;
		else if (cmd_i.shf_op == dlsc_pkg::SHF_ARI)
			sv = $signed(sx[W-1:L]) >>> namt;
		else
			sv = sx[W-1:L] >> namt;
		shf_r = {sv, {L{1'b0}}};
		// single precision keeps the top 32 bits; the extension byte is cut
		if (!ext_prec_i)
		begin
			alu_r[L-1:0] = '0;
			mul_r[L-1:0] = '0;
		end
		rf_d = rf_q;
		flags_d = flags_q;
		// every unit finishes in this cycle; alu, multiplier, shifter all write
		if (active_i && cmd_i.valid)
		begin
			if (cmd_i.alu_op != dlsc_pkg::ALU_NOP)
			begin
				rf_d[{alt_bank_i, cmd_i.alu_d}] = alu_r;
				flags_d.az = alu_r == '0;
				flags_d.an = alu_r[W-1];
				flags_d.av = alu_v;
			end
			if (cmd_i.mul_op != dlsc_pkg::MUL_NOP)
				rf_d[{alt_bank_i, cmd_i.mul_d}] = mul_r;
			if (cmd_i.shf_op != dlsc_pkg::SHF_NOP)
				rf_d[{alt_bank_i, cmd_i.shf_d}] = shf_r;
		end
		// loads come last so a memory write-back wins a shared destination
		for (int p = 0; p < 2; p++)
			if (active_i && ld_en_i[p])
				rf_d[{alt_bank_i, ld_idx_i[p]}] = {ld_data_i[p], {L{1'b0}}};
		for (int p = 0; p < 2; p++)
			st_data_o[p] = rf_q[{alt_bank_i, st_idx_i[p]}][W-1:L];
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			for (int i = 0; i < N; i++)
				rf_q[i] <= dlsc_pkg::RF_RST;
			flags_q <= dlsc_pkg::FLAGS_RST;
		end
		else
		begin
			rf_q <= rf_d;
			flags_q <= flags_d;
		end
	end

	assign flags_o = flags_q;
endmodule

// ### logic/dlsc_pkg.sv
// constants and carrier types shared by the dual lane compute core
// assumes one core clock and commands already decoded by the sequencer
package dlsc_pkg;
	localparam int DATA_W = 32;
	localparam int REG_W = 40;
	localparam int NREG = 16;
	localparam int IDX_W = 4;
	localparam int ADDR_W = 16;
	localparam int INSTR_W = 48;
	localparam int MODE_W = 32;
	localparam int IC_DEPTH = 16;
	// fixed point and single precision words sit in bits 39:8
	localparam int FIX_LSB = 8;
	localparam int MODE_ALT_BIT = 0;
	localparam int MODE_DUAL_BIT = 1;
	localparam int MODE_EXT_BIT = 2;
	localparam logic [MODE_W-1:0] MODE_RST = 32'h0000_0000;
	localparam logic [9:0] FP_BIAS = 10'h07f;
	localparam logic [9:0] FP_EMAX = 10'h0ff;

	typedef logic [REG_W-1:0] dlsc_word_t;
	localparam dlsc_word_t RF_RST = 40'h00_0000_0000;

	typedef enum logic [3:0] {
		ALU_NOP, ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND,
		ALU_OR, ALU_XOR, ALU_FADD, ALU_FSUB
	} dlsc_alu_op_t;
	typedef enum logic [1:0] {MUL_NOP, MUL_FIX, MUL_FLT} dlsc_mul_op_t;
	typedef enum logic [1:0] {SHF_NOP, SHF_LOG, SHF_ARI} dlsc_shf_op_t;

	typedef enum logic [3:0] {
		F_IDLE  = 4'h1,
		F_MISS  = 4'h2,
		F_WAIT  = 4'h4,
		F_CATCH = 4'h8
	} dlsc_fstate_t;

	typedef struct packed {
		logic              en;
		logic              load;
		logic [IDX_W-1:0]  idx;
		logic [ADDR_W-1:0] addr;
	} dlsc_xfer_t;

	typedef struct packed {
		logic             valid;
		dlsc_alu_op_t     alu_op;
		logic [IDX_W-1:0] alu_d;
		logic [IDX_W-1:0] alu_x;
		logic [IDX_W-1:0] alu_y;
		dlsc_mul_op_t     mul_op;
		logic [IDX_W-1:0] mul_d;
		logic [IDX_W-1:0] mul_x;
		logic [IDX_W-1:0] mul_y;
		dlsc_shf_op_t     shf_op;
		logic [IDX_W-1:0] shf_d;
		logic [IDX_W-1:0] shf_x;
		logic [7:0]       shf_amt;
		dlsc_xfer_t       dm;
		dlsc_xfer_t       pm;
	} dlsc_cmd_t;

	typedef struct packed {
		logic                req;
		logic                we;
		logic                pair;
		logic                ifetch;
		logic [ADDR_W-1:0]   addr;
		logic [2*DATA_W-1:0] wdata;
	} dlsc_mreq_t;
	localparam dlsc_mreq_t MREQ_RST = '0;

	typedef struct packed {
		logic             en;
		logic             pair;
		logic [IDX_W-1:0] idx;
	} dlsc_ldtag_t;
	localparam dlsc_ldtag_t TAG_RST = '0;

	typedef struct packed {
		logic az;
		logic an;
		logic av;
	} dlsc_flags_t;
	localparam dlsc_flags_t FLAGS_RST = 3'h0;
endpackage

// ### verif/dlsc_core_sva.sv
// concurrent checks on the ports of the dual lane compute core
// assumes it is bound to dlsc_core and sees one clock and one reset
`timescale 1ns/1ps
module dlsc_core_sva (
	input wire logic                        clock_i,
	input wire logic                        arst_n_i,
	input wire logic                        mode_we_i,
	input wire logic [dlsc_pkg::MODE_W-1:0] mode_wdata_i,
	input wire dlsc_pkg::dlsc_cmd_t         cmd_i,
	input wire logic                        fetch_req_i,
	input wire logic [dlsc_pkg::MODE_W-1:0] mode_o,
	input wire logic                        fetch_ready_o,
	input wire logic                        instr_valid_o,
	input wire dlsc_pkg::dlsc_mreq_t        dm_req_o,
	input wire dlsc_pkg::dlsc_mreq_t        pm_req_o,
	input wire dlsc_pkg::dlsc_flags_t       sec_flags_o
);
	logic dm_cmd;
	logic pm_cmd;

	assign dm_cmd = cmd_i.valid && cmd_i.dm.en;
	assign pm_cmd = cmd_i.valid && cmd_i.pm.en;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	mode_write_a: assert property (mode_we_i |=> mode_o == $past(mode_wdata_i))
		else $error("mode word not taken");
	dm_issue_a: assert property (dm_cmd |=> dm_req_o.req && dm_req_o.we == !$past(cmd_i.dm.load)
		&& dm_req_o.addr == $past(cmd_i.dm.addr)) else $error("data bus access missing");
	dm_cause_a: assert property (dm_req_o.req |-> $past(dm_cmd))
		else $error("data bus access without command");
	dm_no_instr_a: assert property (!dm_req_o.ifetch)
		else $error("instruction fetch on data bus");
	pair_mode_a: assert property (dm_req_o.req |-> dm_req_o.pair == $past(mode_o[1]))
		else $error("pair flag does not follow lane mode");
	single_word_a: assert property (dm_req_o.req && dm_req_o.we && !dm_req_o.pair
		|-> dm_req_o.wdata[63:32] == 32'h0) else $error("single store drives upper word");
	pm_data_a: assert property (pm_cmd |=> pm_req_o.req && !pm_req_o.ifetch)
		else $error("program bus data access lost");
	sec_hold_a: assert property (!mode_o[1] |=> $stable(sec_flags_o))
		else $error("secondary flags moved in single lane");
	fetch_plain_a: assert property (fetch_req_i && fetch_ready_o && !pm_cmd
		|=> pm_req_o.req && pm_req_o.ifetch ##2 instr_valid_o) else $error("plain fetch timing");
	ready_back_a: assert property (instr_valid_o |-> fetch_ready_o)
		else $error("fetch port not idle with instruction");

	pair_c: cover property (dm_req_o.req && dm_req_o.pair);
	hit_c: cover property (fetch_req_i && fetch_ready_o && pm_cmd ##1 instr_valid_o);
	dual_on_c: cover property (mode_we_i && mode_wdata_i[1]);
endmodule

// ### verif/dlsc_core_tb_top.sv
// self-checking bench for the dual lane compute core
// assumes dlsc_mem_model answers both buses one cycle after a request
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED t=%0t %s", $time, m); end end
module dlsc_core_tb_top;
	logic                  clock_i;
	logic                  arst_n_i;
	logic                  mode_we_i;
	logic [31:0]           mode_wdata_i;
	dlsc_pkg::dlsc_cmd_t   cmd_i;
	logic                  fetch_req_i;
	logic [15:0]           fetch_addr_i;
	logic [63:0]           dm_rdata;
	logic [63:0]           pm_rdata;
	logic [31:0]           mode_o;
	logic                  fetch_ready_o;
	logic                  instr_valid_o;
	logic [47:0]           instr_o;
	dlsc_pkg::dlsc_mreq_t  dm_req_o;
	dlsc_pkg::dlsc_mreq_t  pm_req_o;
	dlsc_pkg::dlsc_flags_t pri_flags_o;
	dlsc_pkg::dlsc_flags_t sec_flags_o;
	int                    errors;
	int                    n_tests;
	logic [31:0]           ra [0:7];
	logic [31:0]           sa [0:7];

	dlsc_core #(.IC_DEPTH(4)) dlsc_core_i (
		.clock_i(clock_i), .arst_n_i(arst_n_i), .mode_we_i(mode_we_i),
		.mode_wdata_i(mode_wdata_i), .cmd_i(cmd_i), .fetch_req_i(fetch_req_i),
		.fetch_addr_i(fetch_addr_i), .dm_rdata_i(dm_rdata), .pm_rdata_i(pm_rdata),
		.mode_o(mode_o), .fetch_ready_o(fetch_ready_o), .instr_valid_o(instr_valid_o),
		.instr_o(instr_o), .dm_req_o(dm_req_o), .pm_req_o(pm_req_o),
		.pri_flags_o(pri_flags_o), .sec_flags_o(sec_flags_o));

	dlsc_mem_model dlsc_mem_model_i (
		.clock_i(clock_i), .dm_req_i(dm_req_o), .pm_req_i(pm_req_o),
		.dm_rdata_o(dm_rdata), .pm_rdata_o(pm_rdata));

	initial
	begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	function automatic dlsc_pkg::dlsc_cmd_t xfer(input logic pm, input logic ld,
		input logic [3:0] idx, input logic [15:0] a);
		dlsc_pkg::dlsc_cmd_t c;
		c = '0;
		c.valid = 1'b1;
		if (pm)
			c.pm = {1'b1, ld, idx, a};
		else
			c.dm = {1'b1, ld, idx, a};
		return c;
	endfunction

	function automatic dlsc_pkg::dlsc_cmd_t alu3(input dlsc_pkg::dlsc_alu_op_t op,
		input logic [3:0] d, input logic [3:0] x, input logic [3:0] y);
		dlsc_pkg::dlsc_cmd_t c;
		c = '0;
		c.valid = 1'b1;
		c.alu_op = op;
		c.alu_d = d;
		c.alu_x = x;
		c.alu_y = y;
		return c;
	endfunction

	// every task starts and ends just after a falling edge
	task automatic idle(input int n);
		cmd_i = '0;
		repeat (n) @(negedge clock_i);
	endtask

	task automatic run(input dlsc_pkg::dlsc_cmd_t c);
		cmd_i = c;
		@(negedge clock_i);
	endtask

	task automatic setmode(input logic [31:0] m);
		mode_we_i = 1'b1;
		mode_wdata_i = m;
		@(negedge clock_i);
		mode_we_i = 1'b0;
		`CHK(mode_o, m, "mode word")
		@(negedge clock_i);
	endtask

	task automatic load(input logic [3:0] idx, input logic [63:0] v);
		dlsc_mem_model_i.mem[8'h10 + idx] = v;
		run(xfer(1'b0, 1'b1, idx, 16'h0010 + idx));
		idle(2);
	endtask

	// load data lands two cycles later, so the load task idles that gap itself
	task automatic store(input logic [3:0] idx, input logic [63:0] e, input string m);
		run(xfer(1'b0, 1'b0, idx, 16'h0080));
		`CHK(dm_req_o.wdata, e, m)
		idle(1);
	endtask

	task automatic fetch(input logic [15:0] a, input logic cf, input int lat, input string m);
		int n;
		fetch_req_i = 1'b1;
		fetch_addr_i = a;
		if (cf)
			cmd_i = xfer(1'b1, 1'b1, 4'd15, 16'h0020);
		@(negedge clock_i);
		fetch_req_i = 1'b0;
		cmd_i = '0;
		n = 1;
		while (instr_valid_o !== 1'b1 && n < 20)
		begin
			@(negedge clock_i);
			n++;
		end
		`CHK(n, lat, m)
		`CHK(instr_o, dlsc_mem_model_i.mem[a[7:0]][47:0], m)
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (4000) @(posedge clock_i);
		errors++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		results();
	end

	initial
	begin
		dlsc_pkg::dlsc_cmd_t c;
		logic [63:0]         v;
		errors = 0;
		n_tests = 0;
		arst_n_i = 1'b0;
		mode_we_i = 1'b0;
		mode_wdata_i = 32'h0;
		cmd_i = '0;
		fetch_req_i = 1'b0;
		fetch_addr_i = 16'h0;
		void'($urandom(33444));
		repeat (12) @(negedge clock_i);
		arst_n_i = 1'b1;
		`CHK(mode_o, 32'h0, "mode after reset")
		`CHK(fetch_ready_o, 1'b1, "fetch idle after reset")
		`CHK({dm_req_o.req, pm_req_o.req, instr_valid_o}, 3'h0, "no bus after reset")
		`CHK({pri_flags_o, sec_flags_o}, 6'h0, "flags after reset")
		$display("reset test done");

		setmode(32'h0000_0002);
		for (int i = 0; i < 8; i++)
		begin
			ra[i] = $urandom;
			sa[i] = $urandom;
			load(i[3:0], {sa[i], ra[i]});
			store(i[3:0], {sa[i], ra[i]}, "dual load and store");
		end
		setmode(32'h0000_0003);
		v = {$urandom, $urandom};
		load(4'd0, v);
		store(4'd0, v, "alternate bank");
		setmode(32'h0000_0002);
		store(4'd0, {sa[0], ra[0]}, "primary bank kept");
		$display("dual lane transfer test done");

		c = alu3(dlsc_pkg::ALU_ADD, 4'd8, 4'd0, 4'd1);
		c.mul_op = dlsc_pkg::MUL_FIX;
		c.mul_d = 4'd9;
		c.mul_y = 4'd1;
		c.shf_op = dlsc_pkg::SHF_LOG;
		c.shf_d = 4'd10;
		c.shf_amt = 8'h04;
		run(c);
		store(4'd8, {sa[0] + sa[1], ra[0] + ra[1]}, "alu sum");
		store(4'd9, {sa[0] * sa[1], ra[0] * ra[1]}, "product");
		store(4'd10, {sa[0] << 4, ra[0] << 4}, "shift");
		load(4'd11, {32'h4040_0000, 32'h3f80_0000});
		load(4'd12, {32'h4040_0000, 32'h3f80_0000});
		run(alu3(dlsc_pkg::ALU_FADD, 4'd13, 4'd11, 4'd12));
		store(4'd13, {32'h40c0_0000, 32'h4000_0000}, "float sum");
		// xor, float product and arithmetic right shift in one command
		c = alu3(dlsc_pkg::ALU_XOR, 4'd2, 4'd11, 4'd13);
		c.mul_op = dlsc_pkg::MUL_FLT;
		c.mul_d = 4'd3;
		c.mul_x = 4'd13;
		c.mul_y = 4'd11;
		c.shf_op = dlsc_pkg::SHF_ARI;
		c.shf_d = 4'd4;
		c.shf_x = 4'd1;
		c.shf_amt = 8'hfc;
		run(c);
		store(4'd2, {32'h0080_0000, 32'h7f80_0000}, "logic xor");
		store(4'd3, {32'h4190_0000, 32'h4000_0000}, "float product");
		store(4'd4, {$signed(sa[1]) >>> 4, $signed(ra[1]) >>> 4}, "arith shift");
		run(alu3(dlsc_pkg::ALU_SUB, 4'd14, 4'd0, 4'd0));
		`CHK({pri_flags_o, sec_flags_o}, 6'b100100, "zero flags both lanes")
		idle(1);
		$display("compute test done");

		setmode(32'h0000_0000);
		v = {$urandom, $urandom};
		load(4'd0, v);
		store(4'd0, {32'h0, v[31:0]}, "single lane load");
		run(alu3(dlsc_pkg::ALU_SUB, 4'd0, 4'd1, 4'd14));
		`CHK(pri_flags_o, {ra[1] == 32'h0, ra[1][31], 1'b0}, "primary flags")
		`CHK(sec_flags_o, 3'b100, "secondary flags held")
		idle(1);
		setmode(32'h0000_0002);
		store(4'd0, {sa[0], ra[1]}, "secondary regs held");
		$display("single lane test done");

		for (int i = 0; i < 3; i++)
			dlsc_mem_model_i.mem[8'h40 + 4 * i] = {$urandom, $urandom};
		dlsc_mem_model_i.mem[8'h20] = {$urandom, $urandom};
		fetch(16'h0040, 1'b0, 3, "plain fetch");
		fetch(16'h0044, 1'b1, 4, "conflict miss");
		fetch(16'h0044, 1'b1, 1, "conflict hit");
		fetch(16'h0048, 1'b0, 3, "plain fetch again");
		idle(2);
		$display("fetch test done");
		results();
	end
endmodule

bind dlsc_core dlsc_core_sva dlsc_core_sva_i (
	.clock_i(clock_i), .arst_n_i(arst_n_i), .mode_we_i(mode_we_i),
	.mode_wdata_i(mode_wdata_i), .cmd_i(cmd_i), .fetch_req_i(fetch_req_i),
	.mode_o(mode_o), .fetch_ready_o(fetch_ready_o), .instr_valid_o(instr_valid_o),
	.dm_req_o(dm_req_o), .pm_req_o(pm_req_o), .sec_flags_o(sec_flags_o));

// ### verif/dlsc_mem_model.sv
// dual bus on-chip memory seen from the compute core
// assumes the bench preloads mem; answers one cycle after each request
`timescale 1ns/1ps
module dlsc_mem_model (
	input  wire logic                          clock_i,
	input  wire dlsc_pkg::dlsc_mreq_t          dm_req_i,
	input  wire dlsc_pkg::dlsc_mreq_t          pm_req_i,
	output logic [2*dlsc_pkg::DATA_W-1:0]      dm_rdata_o,
	output logic [2*dlsc_pkg::DATA_W-1:0]      pm_rdata_o
);
	logic [2*dlsc_pkg::DATA_W-1:0] mem [0:255];

	initial
	begin
		dm_rdata_o = '0;
		pm_rdata_o = '0;
	end

	// buses without a read invert their previous output each cycle, so stale data matches only every second cycle
	always @(posedge clock_i)
	begin
		if (dm_req_i.req && dm_req_i.we)
			mem[dm_req_i.addr[7:0]] <= dm_req_i.wdata;
		if (pm_req_i.req && pm_req_i.we)
			mem[pm_req_i.addr[7:0]] <= pm_req_i.wdata;
		dm_rdata_o <= (dm_req_i.req && !dm_req_i.we) ? mem[dm_req_i.addr[7:0]] : ~dm_rdata_o;
		pm_rdata_o <= (pm_req_i.req && !pm_req_i.we) ? mem[pm_req_i.addr[7:0]] : ~pm_rdata_o;
	end
endmodule
